/* File: core/xse_exec.sv */
`timescale 1ns/1ps
`default_nettype none

module xse_exec
  import xse_pkg::*;
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  // Configuration
  input  wire logic                       extension_enable_bit,
  // Instruction stream, one word per instruction cycle
  input  wire logic                       instr_valid,
  input  wire logic [15:0]                instr_word,
  // Core state read by the unit
  input  wire logic [7:0]                 working_reg,
  input  wire logic [xse_pkg::PC_W-1:0]   prog_counter,
  input  wire logic [7:0]                 prog_counter_latch_high,
  input  wire logic [4:0]                 prog_counter_latch_upper,
  input  wire logic [xse_pkg::PC_W-1:0]   return_stack_top,
  // Direct pointer load from the core
  input  wire logic                       ptr_load,
  input  wire logic [1:0]                 ptr_load_sel,
  input  wire logic [xse_pkg::ADDR_W-1:0] ptr_load_value,
  // Data memory
  output logic      [xse_pkg::ADDR_W-1:0] mem_addr,
  output logic                            mem_rd_en,
  input  wire logic [7:0]                 mem_rd_data,
  output logic                            mem_wr_en,
  output logic      [7:0]                 mem_wr_data,
  // Pointers
  output logic      [xse_pkg::ADDR_W-1:0] indirect_pointer_0,
  output logic      [xse_pkg::ADDR_W-1:0] indirect_pointer_1,
  output logic      [xse_pkg::ADDR_W-1:0] frame_pointer_reg,
  // Program flow
  output logic                            pc_load,
  output logic      [xse_pkg::PC_W-1:0]   pc_value,
  output logic                            stack_push,
  output logic      [xse_pkg::PC_W-1:0]   stack_push_data,
  output logic                            busy
);

  typedef struct packed {
    xse_state_e             state;
    logic [2:0][ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0]      mem_addr;
    logic                   mem_rd_en;
    logic                   mem_wr_en;
    logic [7:0]             mem_wr_data;
    logic [7:0]             move_data;
    logic                   src_ind;
    logic                   to_indexed;
    logic                   pc_load;
    logic [PC_W-1:0]        pc_value;
    logic                   stack_push;
    logic [PC_W-1:0]        stack_push_data;
    logic                   busy;
  } xse_state_s;

  localparam xse_state_s ST_RESET = '{
    state:           ST_DECODE,
    ptr:             {PTR_RST, PTR_RST, PTR_RST},
    mem_addr:        PTR_RST,
    mem_rd_en:       1'b0,
    mem_wr_en:       1'b0,
    mem_wr_data:     DATA_ZERO,
    move_data:       DATA_ZERO,
    src_ind:         1'b0,
    to_indexed:      1'b0,
    pc_load:         1'b0,
    pc_value:        PC_RST,
    stack_push:      1'b0,
    stack_push_data: PC_RST,
    busy:            1'b0
  };

  xse_state_s st_reg;
  xse_state_s st_next;

  logic [ADDR_W-1:0] src_addr;
  logic              src_ind;
  logic [ADDR_W-1:0] dst_addr;
  logic              dst_ind;
  logic [7:0]        src_data;
  logic [1:0]        sel;
  logic [5:0]        imm6;

  ////////////////////////////////////////////////////////////////////////////
  // Address formation

  xse_index_addr u_src (
    .base     (st_reg.ptr[SEL_FRAME]),
    .offset   (instr_word[6:0]),
    .addr     (src_addr),
    .indirect (src_ind)
  );

  xse_index_addr u_dst (
    .base     (st_reg.ptr[SEL_FRAME]),
    .offset   (instr_word[6:0]),
    .addr     (dst_addr),
    .indirect (dst_ind)
  );

  assign sel  = instr_word[7:6];
  assign imm6 = instr_word[5:0];

  // Read data is live in the cycle the read strobe stands, held afterwards
  assign src_data = st_reg.mem_rd_en ? mem_rd_data : st_reg.move_data;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next            = st_reg;
    st_next.mem_rd_en  = 1'b0;
    st_next.mem_wr_en  = 1'b0;
    st_next.pc_load    = 1'b0;
    st_next.stack_push = 1'b0;
    if (st_reg.mem_rd_en) begin
      st_next.move_data = mem_rd_data;
    end
    unique case (st_reg.state)
      ST_DECODE: begin
        if (instr_valid && extension_enable_bit) begin
          if (instr_word[15:8] == OPC_MOVE_IDX) begin
            st_next.mem_addr   = src_addr;
            st_next.mem_rd_en  = 1'b1;
            st_next.src_ind    = src_ind;
            st_next.to_indexed = instr_word[MOVE_KIND_BIT];
            st_next.state      = ST_MOVE_WORD2;
          end else if (instr_word[15:8] == OPC_PUSH_LIT) begin
            st_next.mem_addr         = st_reg.ptr[SEL_FRAME];
            st_next.mem_wr_data      = instr_word[7:0];
            st_next.mem_wr_en        = 1'b1;
            st_next.ptr[SEL_FRAME]   = st_reg.ptr[SEL_FRAME] - FP_STEP;
          end else if (instr_word[15:8] == OPC_PTR_SUB) begin
            if (sel == SEL_SUB_RETURN) begin
              st_next.ptr[SEL_FRAME] = st_reg.ptr[SEL_FRAME] -
                                       {6'h00, imm6};
              st_next.pc_load        = 1'b1;
              st_next.pc_value       = return_stack_top;
              st_next.state          = ST_IDLE_CYCLE;
            end else begin
              // No flags exist here to disturb
              st_next.ptr[sel] = st_reg.ptr[sel] - {6'h00, imm6};
            end
          end else if (instr_word == OPC_CALL_WORK) begin
            st_next.stack_push      = 1'b1;
            st_next.stack_push_data = prog_counter + PC_STEP;
            st_next.state           = ST_CALL_LOAD;
          end
        end
      end
      ST_MOVE_WORD2: begin
        if (instr_valid) begin
          st_next.state = ST_DECODE;
          // Second word must carry the 1111 prefix
          if (instr_word[15:12] == OPC_WORD2_PFX) begin
            st_next.mem_wr_data = st_reg.src_ind ? DATA_ZERO : src_data;
            if (st_reg.to_indexed) begin
              st_next.mem_addr  = dst_addr;
              st_next.mem_wr_en = !dst_ind;
            end else begin
              st_next.mem_addr  = instr_word[ADDR_W-1:0];
              st_next.mem_wr_en = 1'b1;
            end
          end
        end
      end
      ST_IDLE_CYCLE: begin
        // Fetched word is flushed as a nop
        if (instr_valid) begin
          st_next.state = ST_DECODE;
        end
      end
      ST_CALL_LOAD: begin
        st_next.pc_load  = 1'b1;
        st_next.pc_value = {prog_counter_latch_upper,
                            prog_counter_latch_high, working_reg};
        st_next.state    = ST_IDLE_CYCLE;
      end
    endcase
    // Core load wins over a same-cycle update of the same pointer
    if (ptr_load && (ptr_load_sel != SEL_SUB_RETURN)) begin
      st_next.ptr[ptr_load_sel] = ptr_load_value;
    end
    // Busy kept in a flop so the output carries no decode glitch
    st_next.busy = (st_next.state != ST_DECODE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign mem_addr           = st_reg.mem_addr;
  assign mem_rd_en          = st_reg.mem_rd_en;
  assign mem_wr_en          = st_reg.mem_wr_en;
  assign mem_wr_data        = st_reg.mem_wr_data;
  assign indirect_pointer_0 = st_reg.ptr[0];
  assign indirect_pointer_1 = st_reg.ptr[1];
  assign frame_pointer_reg  = st_reg.ptr[SEL_FRAME];
  assign pc_load            = st_reg.pc_load;
  assign pc_value           = st_reg.pc_value;
  assign stack_push         = st_reg.stack_push;
  assign stack_push_data    = st_reg.stack_push_data;
  assign busy               = st_reg.busy;

endmodule

`default_nettype wire

/* File: core/xse_index_addr.sv */
`timescale 1ns/1ps
`default_nettype none

// Frame pointer plus unsigned offset; wraps inside the data space
module xse_index_addr
  import xse_pkg::*;
(
  // Operands
  input  wire logic [xse_pkg::ADDR_W-1:0] base,
  input  wire logic [6:0]                 offset,
  // Result
  output logic      [xse_pkg::ADDR_W-1:0] addr,
  output logic                            indirect
);

  always_comb begin
    addr     = base + {5'h00, offset};
    indirect = xse_is_indirect(addr);
  end

endmodule

`default_nettype wire

/* File: core/xse_pkg.sv */
package xse_pkg;

  localparam int ADDR_W = 12;
  localparam int PC_W   = 21;

  // Opcode fields
  localparam logic [7:0]  OPC_MOVE_IDX   = 8'hEB;
  localparam logic [7:0]  OPC_PUSH_LIT   = 8'hFA;
  localparam logic [7:0]  OPC_PTR_SUB    = 8'hE9;
  localparam logic [3:0]  OPC_WORD2_PFX  = 4'hF;
  localparam logic [15:0] OPC_CALL_WORK  = 16'h0014;
  localparam logic [1:0]  SEL_FRAME      = 2'h2;
  localparam logic [1:0]  SEL_SUB_RETURN = 2'h3;
  localparam int          MOVE_KIND_BIT  = 7;

  // Indirect access windows: each base plus four following bytes
  localparam logic [ADDR_W-1:0] IND_BASE0 = 12'hFEB;
  localparam logic [ADDR_W-1:0] IND_BASE1 = 12'hFE3;
  localparam logic [ADDR_W-1:0] IND_BASE2 = 12'hFDB;
  localparam logic [ADDR_W-1:0] IND_SPAN  = 12'h005;

  // Steps and reset values
  localparam logic [PC_W-1:0]   PC_STEP   = 21'h000002;
  localparam logic [PC_W-1:0]   PC_RST    = 21'h000000;
  localparam logic [ADDR_W-1:0] FP_STEP   = 12'h001;
  localparam logic [ADDR_W-1:0] PTR_RST   = 12'h000;
  localparam logic [7:0]        DATA_ZERO = 8'h00;

  typedef enum logic [1:0] {
    ST_DECODE     = 2'b00,
    ST_MOVE_WORD2 = 2'b01,
    ST_IDLE_CYCLE = 2'b10,
    ST_CALL_LOAD  = 2'b11
  } xse_state_e;

  function automatic logic xse_in_window(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] b);
    logic [ADDR_W-1:0] d;
    d = a - b;
    return (a >= b) && (d < IND_SPAN);
  endfunction

  function automatic logic xse_is_indirect(input logic [ADDR_W-1:0] a);
    return xse_in_window(a, IND_BASE0) || xse_in_window(a, IND_BASE1) ||
           xse_in_window(a, IND_BASE2);
  endfunction

endpackage

/* File: verification/tb_extended_stack_instr_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_extended_stack_instr_exec;
  import xse_pkg::*;
  logic        clock, sys_rst, xe, v, pl, rd, wr, pcld, sp, busy;
  logic [15:0] w;
  logic [7:0]  wv, lh, rdd, wd;
  logic [4:0]  lu;
  logic [1:0]  sel;
  logic [20:0] pc, stk_top, pcv, spd;
  logic [11:0] pv, a, ip0, ip1, fp;
  logic [7:0]  mem [4096];
  int          num_errors, checks_done;
  xse_exec i_dut (.clock(clock), .sys_rst(sys_rst),
    .extension_enable_bit(xe), .instr_valid(v), .instr_word(w),
    .working_reg(wv), .prog_counter(pc), .prog_counter_latch_high(lh),
    .prog_counter_latch_upper(lu), .return_stack_top(stk_top),
    .ptr_load(pl), .ptr_load_sel(sel), .ptr_load_value(pv),
    .mem_addr(a), .mem_rd_en(rd), .mem_rd_data(rdd), .mem_wr_en(wr),
    .mem_wr_data(wd), .indirect_pointer_0(ip0), .indirect_pointer_1(ip1),
    .frame_pointer_reg(fp), .pc_load(pcld), .pc_value(pcv),
    .stack_push(sp), .stack_push_data(spd), .busy(busy));
  // Data memory answers in the same cycle as the read strobe
  assign rdd = mem[a];
  always @(posedge clock) if (wr) mem[a] <= wd;
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic vv, input logic [15:0] ww);
    @(negedge clock);
    v = vv;
    w = ww;
    pl = 1'b0;
  endtask
  task automatic ld(input logic [1:0] s, input logic [11:0] val);
    @(negedge clock);
    v = 1'b0;
    pl = 1'b1;
    sel = s;
    pv = val;
  endtask
  task automatic t_stack();
    ld(2'h0, 12'h010);
    ld(2'h1, 12'h000);
    ld(2'h2, 12'h1EC);
    step(1, 16'hFA08);
    step(1, 16'hFA55);
    step(1, 16'hE93F);
    step(1, 16'hE941);
    step(1, 16'hE9A3);
    step(0, 16'h0000);
    cmp(mem[12'h1EC], 8'h08);
    cmp(mem[12'h1EB], 8'h55);
    cmp(ip0, 12'hFD1);
    cmp(ip1, 12'hFFF);
    cmp(fp, 12'h1C7);
  endtask
  task automatic t_ret();
    ld(2'h2, 12'h3FF);
    stk_top = 21'h012345;
    mem[12'h3DC] = 8'hC3;
    step(1, 16'hE9E3);
    // Push word here must be swallowed by the idle cycle
    step(1, 16'hFA77);
    cmp(pcld, 1'b1);
    cmp(pcv, 21'h012345);
    step(0, 16'h0000);
    cmp(busy, 1'b0);
    cmp(fp, 12'h3DC);
    step(0, 16'h0000);
    cmp(mem[12'h3DC], 8'hC3);
  endtask
  task automatic t_moves();
    mem[12'h085] = 8'h33;
    mem[12'h0FF] = 8'h77;
    mem[12'h0AD] = 8'hEE;
    mem[12'hFEB] = 8'h5A;
    ld(2'h2, 12'h080);
    // destinations kept off flow and stack top bytes
    step(1, 16'hEB05);
    step(1, 16'hF0AB);
    step(1, 16'hEB7F);
    step(1, 16'hF0AC);
    step(1, 16'hEB85);
    step(1, 16'hF006);
    ld(2'h2, 12'hFE0);
    step(1, 16'hEB0B);
    step(1, 16'hF0AD);
    step(1, 16'hEB85);
    step(1, 16'hF00B);
    step(0, 16'h0000);
    step(0, 16'h0000);
    cmp(mem[12'h0AB], 8'h33);
    cmp(mem[12'h0AC], 8'h77);
    cmp(mem[12'h086], 8'h33);
    cmp(mem[12'h0AD], 8'h00);
    cmp(mem[12'hFEB], 8'h5A);
  endtask
  task automatic t_off();
    ld(2'h2, 12'h200);
    xe = 1'b0;
    mem[12'h200] = 8'hA5;
    step(1, 16'hFA99);
    step(1, 16'h0014);
    step(0, 16'h0000);
    cmp(sp, 1'b0);
    cmp(mem[12'h200], 8'hA5);
    cmp(fp, 12'h200);
    xe = 1'b1;
  endtask
  task automatic t_call();
    pc = 21'h000100;
    lh = 8'h10;
    lu = 5'h00;
    wv = 8'h06;
    step(1, 16'h0014);
    step(0, 16'h0000);
    cmp(sp, 1'b1);
    cmp(spd, 21'h000102);
    step(0, 16'h0000);
    cmp(pcld, 1'b1);
    cmp(sp, 1'b0);
    cmp(pcv, 21'h001006);
    step(1, 16'h0000);
    step(0, 16'h0000);
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Whole run is about 45 cycles; the limit of 2000 cycles leaves wide margin
  initial begin
    #50000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    {sys_rst, xe, v, pl} = 4'hC;
    {w, sel, pv, wv, lh, lu} = '0;
    {pc, stk_top} = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    t_stack();
    t_ret();
    t_moves();
    t_off();
    t_call();
    finish_test();
  end
endmodule
`default_nettype wire

/* File: verification/xse_exec_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module xse_exec_checker
  import xse_pkg::*;
(
  // Clock, reset and stream
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic                       extension_enable_bit,
  input wire logic                       instr_valid,
  input wire logic [15:0]                instr_word,
  input wire logic [xse_pkg::PC_W-1:0]   prog_counter,
  input wire logic [xse_pkg::PC_W-1:0]   return_stack_top,
  input wire logic                       ptr_load,
  // Unit outputs
  input wire logic [xse_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                       mem_rd_en,
  input wire logic                       mem_wr_en,
  input wire logic [7:0]                 mem_wr_data,
  input wire logic [xse_pkg::ADDR_W-1:0] indirect_pointer_0,
  input wire logic [xse_pkg::ADDR_W-1:0] frame_pointer_reg,
  input wire logic                       pc_load,
  input wire logic [xse_pkg::PC_W-1:0]   pc_value,
  input wire logic                       stack_push,
  input wire logic [xse_pkg::PC_W-1:0]   stack_push_data,
  input wire logic                       busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // A same-cycle pointer load wins, so such words are left out
  logic dec;
  logic [7:0] op;
  logic [5:0] k;
  assign dec = instr_valid && extension_enable_bit && !busy && !ptr_load;
  assign op = instr_word[15:8];
  assign k = instr_word[5:0];
  sequence s_ret_flush;
    dec && op == OPC_PTR_SUB && instr_word[7:6] == 2'h3 ##1 instr_valid;
  endsequence
  sequence s_move_abs;
    dec && op == OPC_MOVE_IDX && !instr_word[7] ##1
      instr_valid && instr_word[15:12] == OPC_WORD2_PFX;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_push_write: assert property (dec && op == OPC_PUSH_LIT |=>
    mem_wr_en && mem_addr == $past(frame_pointer_reg) &&
    mem_wr_data == $past(instr_word[7:0]) &&
    frame_pointer_reg == $past(frame_pointer_reg) - FP_STEP)
    else $error("push write wrong");
  chk_ext_gate: assert property (
    !extension_enable_bit && instr_valid && !busy |=>
    !mem_wr_en && !pc_load && !stack_push && !busy)
    else $error("word acted on while extension off");
  chk_sub_ptr: assert property (
    dec && op == OPC_PTR_SUB && instr_word[7:6] == 2'h0 |=>
    indirect_pointer_0 == $past(indirect_pointer_0) - {6'h00, $past(k)})
    else $error("pointer subtract wrong");
  chk_ret_load: assert property (
    dec && op == OPC_PTR_SUB && instr_word[7:6] == 2'h3 |=>
    pc_load && busy && pc_value == $past(return_stack_top) &&
    frame_pointer_reg == $past(frame_pointer_reg) - {6'h00, $past(k)})
    else $error("subtract-return wrong");
  chk_ret_idle: assert property (s_ret_flush |=>
    !busy && !mem_wr_en && !pc_load)
    else $error("second cycle not idle");
  chk_move_src: assert property (dec && op == OPC_MOVE_IDX |=>
    mem_rd_en && busy && mem_addr ==
    $past(frame_pointer_reg) + {5'h00, $past(instr_word[6:0])})
    else $error("move source address wrong");
  chk_move_dest: assert property (s_move_abs |=>
    mem_wr_en && !busy && mem_addr == $past(instr_word[11:0]))
    else $error("move destination wrong");
  chk_call_push: assert property (
    dec && instr_word == OPC_CALL_WORK |=>
    stack_push && stack_push_data == $past(prog_counter) + PC_STEP
    ##1 pc_load && !stack_push)
    else $error("call push order wrong");
endmodule
bind xse_exec xse_exec_checker i_chk (.clock(clock), .sys_rst(sys_rst),
  .extension_enable_bit(extension_enable_bit), .instr_valid(instr_valid),
  .instr_word(instr_word), .prog_counter(prog_counter),
  .return_stack_top(return_stack_top), .ptr_load(ptr_load),
  .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
  .mem_wr_data(mem_wr_data), .indirect_pointer_0(indirect_pointer_0),
  .frame_pointer_reg(frame_pointer_reg), .pc_load(pc_load),
  .pc_value(pc_value), .stack_push(stack_push),
  .stack_push_data(stack_push_data), .busy(busy));
`default_nettype wire
